// ==== design/tpts_sequencer.sv ====
// transmit pulse template sequencer top
`timescale 1ns/1ps
// Notes on behaviour
// - the template holds eight 4-bit codes, each picking one of 16 output levels.
// - entries are reached only indirectly, index at 16h and data at 17h.
// - each entry drives the level for one of eight step periods in one line clock cycle.
// - entry 0 goes out on the first falling step clock edge after the line clock goes low.
// - entries 0 to 3 shape the body of the pulse and 4 to 7 the tail.
// - a positive mark puts the body on the positive output and the tail on the negative, a negative mark swaps them.
// - the output not carrying body or tail is held at ground.
// - code 0000 is zero level and 1111 full swing, rising in between.
// - once the enable bit is set again pulses use the new entries.
// - writing an index then reading the data register returns that entry's code.
module tpts_sequencer
   import tpts_pkg::*;
(
   input wire logic CLOCK,
   input wire logic RESET,
   input wire logic [7:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [7:0] RDATA,
   input wire logic TRANSMIT_LINE_CLOCK,
   input wire logic STEP_CLOCK,
   input wire logic MARK_POS,
   input wire logic MARK_NEG,
   output logic [3:0] POS_LINE_OUTPUT,
   output logic [3:0] NEG_LINE_OUTPUT,
   output logic POS_GROUND,
   output logic NEG_GROUND
);
   localparam int IW = $clog2(ENTRY_COUNT);

   logic [IW-1:0] index_reg;
   logic [IW-1:0] index_next;
   logic enable_reg;
   logic enable_next;
   logic [7:0] rdata_reg;
   logic [7:0] rdata_next;
   logic table_wr;
   logic [CODE_WIDTH-1:0] host_code;
   logic [CODE_WIDTH-1:0] seq_code;

   tpts_seq_e state_reg;
   tpts_seq_e state_next;
   logic [IW-1:0] step_reg;
   logic [IW-1:0] step_next;
   logic pol_neg_reg;
   logic pol_neg_next;
   logic active_reg;
   logic active_next;
   logic [3:0] pos_reg;
   logic [3:0] pos_next;
   logic [3:0] neg_reg;
   logic [3:0] neg_next;
   logic posg_reg;
   logic posg_next;
   logic negg_reg;
   logic negg_next;
   logic line_fall;
   logic step_fall;
   logic [IW-1:0] seq_idx;
   logic step_launch;
   logic step_last;
   logic seq_done;
   logic in_tail;
   logic drive_pos;
   logic hit_index;
   logic hit_value;
   logic hit_config;
   logic hit_status;

   tpts_table #(
      .DEPTH(ENTRY_COUNT),
      .WIDTH(CODE_WIDTH)
   ) u_table (
      .clk(CLOCK),
      .rst(RESET),
      .wr_en(table_wr),
      .wr_idx(index_reg),
      .wr_data(WDATA[CODE_WIDTH-1:0]),
      .rd_idx_a(index_reg),
      .rd_data_a(host_code),
      .rd_idx_b(seq_idx),
      .rd_data_b(seq_code)
   );

   tpts_edge u_line_edge (
      .clk(CLOCK),
      .rst(RESET),
      .level_in(TRANSMIT_LINE_CLOCK),
      .fall(line_fall),
      .rise()
   );

   tpts_edge u_step_edge (
      .clk(CLOCK),
      .rst(RESET),
      .level_in(STEP_CLOCK),
      .fall(step_fall),
      .rise()
   );

   // address decode, shared by the write and read paths
   assign hit_index = (ADDR == WAVEFORM_ENTRY_INDEX_ADDR);
   assign hit_value = (ADDR == WAVEFORM_ENTRY_VALUE_ADDR);
   assign hit_config = (ADDR == SHAPER_CONFIG_ADDR);
   assign hit_status = (ADDR == SHAPER_STATUS_ADDR);

   // index register: only the low bits pick an entry, higher bits are dropped
   always_comb begin
      index_next = index_reg;
      if (WR && hit_index) begin
         index_next = WDATA[IW-1:0];
      end
   end

   always_ff @(posedge CLOCK or posedge RESET) begin
      if (RESET) begin
         index_reg <= INDEX_RESET;
      end else begin
         index_reg <= index_next;
      end
   end

   // table writes are taken any time, keeping enable low while loading is up to software
   assign table_wr = WR && hit_value;

   always_comb begin
      enable_next = enable_reg;
      if (WR && hit_config) begin
         enable_next = WDATA[TEMPLATE_ENABLE_BIT];
      end
   end

   always_ff @(posedge CLOCK or posedge RESET) begin
      if (RESET) begin
         enable_reg <= TEMPLATE_ENABLE_RESET;
      end else begin
         enable_reg <= enable_next;
      end
   end

   // read data stand for one cycle only and are zero otherwise
   always_comb begin
      rdata_next = 8'h00;
      if (RD) begin
         if (hit_index) begin
            rdata_next = {{(8 - IW){1'b0}}, index_reg};
         end else if (hit_value) begin
            rdata_next = {{(8 - CODE_WIDTH){1'b0}}, host_code};
         end else if (hit_config) begin
            rdata_next = {7'h00, enable_reg};
         end else if (hit_status) begin
            rdata_next = {1'b0, pol_neg_reg, active_reg, state_reg == SEQ_RUN, 1'b0, step_reg};
         end else begin
            rdata_next = 8'h00;
         end
      end
   end

   always_ff @(posedge CLOCK or posedge RESET) begin
      if (RESET) begin
         rdata_reg <= 8'h00;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   // sequencer: marks are sampled as the line clock falls, then eight step-clock falls play the template
   always_comb begin
      state_next = state_reg;
      step_next = step_reg;
      pol_neg_next = pol_neg_reg;
      active_next = active_reg;
      case (state_reg)
         SEQ_IDLE: begin
            // line falls while a sequence runs are not seen, one sequence per line cycle
            if (line_fall) begin
               // without enable no codes are used, the line just idles at zero
               active_next = enable_reg & (MARK_POS | MARK_NEG);
               // both marks high counts as positive
               pol_neg_next = MARK_NEG & ~MARK_POS;
               step_next = '0;
               state_next = SEQ_WAIT;
            end
         end
         SEQ_WAIT: begin
            if (step_fall) begin
               state_next = SEQ_RUN;
            end
         end
         SEQ_RUN: begin
            if (step_fall) begin
               step_next = IW'(step_reg + 1'b1);
            end
            if (seq_done) begin
               state_next = SEQ_IDLE;
            end
         end
         default: begin
            state_next = SEQ_IDLE;
         end
      endcase
   end

   always_ff @(posedge CLOCK or posedge RESET) begin
      if (RESET) begin
         state_reg <= SEQ_IDLE;
         step_reg <= '0;
         pol_neg_reg <= 1'b0;
         active_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         step_reg <= step_next;
         pol_neg_reg <= pol_neg_next;
         active_reg <= active_next;
      end
   end

   // step_reg names the entry on the line, so the table is read one entry ahead of it
   always_comb begin
      seq_idx = IW'(step_reg + 1'b1);
      if (state_reg == SEQ_WAIT) begin
         seq_idx = '0;
      end
   end

   assign step_last = (step_reg == IW'(ENTRY_COUNT - 1));
   assign seq_done = step_fall && (state_reg == SEQ_RUN) && step_last;
   assign step_launch = step_fall && ((state_reg == SEQ_WAIT) || (state_reg == SEQ_RUN && !step_last));
   assign in_tail = (seq_idx >= IW'(BODY_ENTRIES));
   // body on the marked side, tail on the other one
   assign drive_pos = (in_tail == pol_neg_reg);

   // line outputs: the side that carries no code is always grounded
   always_comb begin
      pos_next = pos_reg;
      neg_next = neg_reg;
      posg_next = posg_reg;
      negg_next = negg_reg;
      if (seq_done || (step_launch && !active_reg)) begin
         // zero code and both amplifiers grounded between pulses
         pos_next = CODE_ZERO;
         neg_next = CODE_ZERO;
         posg_next = 1'b1;
         negg_next = 1'b1;
      end else if (step_launch && drive_pos) begin
         pos_next = seq_code;
         neg_next = CODE_ZERO;
         posg_next = 1'b0;
         negg_next = 1'b1;
      end else if (step_launch) begin
         pos_next = CODE_ZERO;
         neg_next = seq_code;
         posg_next = 1'b1;
         negg_next = 1'b0;
      end
   end

   always_ff @(posedge CLOCK or posedge RESET) begin
      if (RESET) begin
         pos_reg <= CODE_ZERO;
         neg_reg <= CODE_ZERO;
         posg_reg <= 1'b1;
         negg_reg <= 1'b1;
      end else begin
         pos_reg <= pos_next;
         neg_reg <= neg_next;
         posg_reg <= posg_next;
         negg_reg <= negg_next;
      end
   end

   assign RDATA = rdata_reg;
   assign POS_LINE_OUTPUT = pos_reg;
   assign NEG_LINE_OUTPUT = neg_reg;
   assign POS_GROUND = posg_reg;
   assign NEG_GROUND = negg_reg;
endmodule

// ==== design/tpts_pkg.sv ====
// constants shared by the transmit pulse template sequencer
package tpts_pkg;
   localparam logic [7:0] WAVEFORM_ENTRY_INDEX_ADDR = 8'h16;
   localparam logic [7:0] WAVEFORM_ENTRY_VALUE_ADDR = 8'h17;
   localparam logic [7:0] SHAPER_CONFIG_ADDR = 8'h18;
   localparam logic [7:0] SHAPER_STATUS_ADDR = 8'h19;
   localparam int TEMPLATE_ENABLE_BIT = 0;
   localparam int ENTRY_COUNT = 8;
   localparam int CODE_WIDTH = 4;
   localparam int BODY_ENTRIES = 4;
   localparam logic [2:0] INDEX_RESET = 3'h0;
   localparam logic [3:0] CODE_RESET = 4'h0;
   localparam logic [3:0] CODE_ZERO = 4'h0;
   localparam logic TEMPLATE_ENABLE_RESET = 1'b0;
   typedef enum logic [2:0] {
      SEQ_IDLE = 3'b001,
      SEQ_WAIT = 3'b010,
      SEQ_RUN = 3'b100
   } tpts_seq_e;
endpackage

// ==== design/tpts_edge.sv ====
// edge detector for a synchronous strobe
`timescale 1ns/1ps
module tpts_edge (
   input wire logic clk,
   input wire logic rst,
   input wire logic level_in,
   output logic fall,
   output logic rise
);
   logic last_reg;
   logic last_next;
   always_comb begin
      last_next = level_in;
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         last_reg <= 1'b0;
      end else begin
         last_reg <= last_next;
      end
   end
   assign fall = last_reg & ~level_in;
   assign rise = ~last_reg & level_in;
endmodule

// ==== design/tpts_table.sv ====
// eight-entry level code table with one write and two read ports
`timescale 1ns/1ps
module tpts_table
   import tpts_pkg::*;
#(
   parameter int DEPTH = ENTRY_COUNT,
   parameter int WIDTH = CODE_WIDTH
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic wr_en,
   input wire logic [$clog2(DEPTH)-1:0] wr_idx,
   input wire logic [WIDTH-1:0] wr_data,
   input wire logic [$clog2(DEPTH)-1:0] rd_idx_a,
   output logic [WIDTH-1:0] rd_data_a,
   input wire logic [$clog2(DEPTH)-1:0] rd_idx_b,
   output logic [WIDTH-1:0] rd_data_b
);
   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [WIDTH-1:0] mem_next [DEPTH];
   always_comb begin
      for (int i = 0; i < DEPTH; i++) begin
         mem_next[i] = mem_reg[i];
      end
      if (wr_en) begin
         mem_next[wr_idx] = wr_data;
      end
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem_reg[i] <= '0;
         end
      end else begin
         for (int i = 0; i < DEPTH; i++) begin
            mem_reg[i] <= mem_next[i];
         end
      end
   end
   assign rd_data_a = mem_reg[rd_idx_a];
   assign rd_data_b = mem_reg[rd_idx_b];
endmodule

// ==== testbench/tpts_sequencer_props.sv ====
// port assertions for the pulse template sequencer
`timescale 1ns/1ps
module tpts_sequencer_props
   import tpts_pkg::*;
(
   input wire logic CLOCK,
   input wire logic RESET,
   input wire logic [7:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   input wire logic [7:0] RDATA,
   input wire logic STEP_CLOCK,
   input wire logic [3:0] POS_LINE_OUTPUT,
   input wire logic [3:0] NEG_LINE_OUTPUT,
   input wire logic POS_GROUND,
   input wire logic NEG_GROUND
);
   logic [3:0] shadow_reg [8];
   logic [2:0] idx_reg;
   logic en_reg;
   logic [7:0] exp_reg;
   default clocking @(posedge CLOCK); endclocking
   default disable iff (RESET);
   // mirror of software writes, reset like the table
   always_ff @(posedge CLOCK or posedge RESET) begin
      if (RESET) begin
         shadow_reg <= '{default: 4'h0};
         idx_reg <= 3'h0;
         en_reg <= 1'b0;
         exp_reg <= 8'h00;
      end else begin
         exp_reg <= {4'h0, shadow_reg[idx_reg]};
         if (WR && ADDR == WAVEFORM_ENTRY_INDEX_ADDR) idx_reg <= WDATA[2:0];
         if (WR && ADDR == WAVEFORM_ENTRY_VALUE_ADDR) shadow_reg[idx_reg] <= WDATA[3:0];
         if (WR && ADDR == SHAPER_CONFIG_ADDR) en_reg <= WDATA[TEMPLATE_ENABLE_BIT];
      end
   end
   a_read_idle_zero: assert property (!$past(RD) |-> RDATA == 8'h00)
      else $error("read data not zero outside a read");
   a_unmapped_read_zero: assert property (($past(RD) && ($past(ADDR) < 8'h16 || $past(ADDR) > 8'h19))
      |-> RDATA == 8'h00) else $error("unmapped read not zero");
   a_entry_read_back: assert property (($past(RD) && $past(ADDR) == WAVEFORM_ENTRY_VALUE_ADDR)
      |-> RDATA == exp_reg) else $error("entry read back wrong");
   a_one_side_grounded: assert property (POS_GROUND || NEG_GROUND)
      else $error("both outputs driving");
   a_grounded_code_zero: assert property ((!POS_GROUND || POS_LINE_OUTPUT == 4'h0)
      && (!NEG_GROUND || NEG_LINE_OUTPUT == 4'h0)) else $error("grounded side carries a code");
   // outputs move only after a step fall, never while the step clock is high
   a_step_paced: assert property (($changed(POS_LINE_OUTPUT) || $changed(NEG_LINE_OUTPUT))
      |-> !STEP_CLOCK) else $error("output changed off the step clock");
   a_drive_bounded: assert property ($fell(POS_GROUND) |-> ##[1:200] POS_GROUND)
      else $error("positive side drove too long");
   a_disabled_idle: assert property ((!en_reg && POS_GROUND && NEG_GROUND)
      |=> (POS_GROUND && NEG_GROUND)) else $error("pulse sent with template disabled");
endmodule
bind tpts_sequencer tpts_sequencer_props u_props (.CLOCK(CLOCK), .RESET(RESET), .ADDR(ADDR), .WDATA(WDATA),
   .WR(WR), .RD(RD), .RDATA(RDATA), .STEP_CLOCK(STEP_CLOCK), .POS_LINE_OUTPUT(POS_LINE_OUTPUT),
   .NEG_LINE_OUTPUT(NEG_LINE_OUTPUT), .POS_GROUND(POS_GROUND), .NEG_GROUND(NEG_GROUND));

// ==== testbench/tpts_line_model.sv ====
// line transformer model: differential level across the primary
`timescale 1ns/1ps
module tpts_line_model (
   input wire logic [3:0] pos_code,
   input wire logic [3:0] neg_code,
   input wire logic pos_gnd,
   input wire logic neg_gnd,
   output logic signed [5:0] swing
);
   // a grounded side adds nothing, so the pulse shows only differentially
   always_comb begin
      swing = $signed({2'b00, pos_gnd ? 4'h0 : pos_code}) - $signed({2'b00, neg_gnd ? 4'h0 : neg_code});
   end
endmodule

// ==== testbench/tpts_sequencer_tb.sv ====
// self-checking bench for the pulse template sequencer
`timescale 1ns/1ps
module tpts_sequencer_tb import tpts_pkg::*;;
   logic clock, reset, wr, rd, tlc, step, mp_in, mn_in, pg, ng;
   logic [7:0] addr, wdata, rdata;
   logic [3:0] po, no;
   logic signed [5:0] swing;
   int failures, checked;
   localparam logic [3:0] cv [8] = '{4'h3, 4'h9, 4'hf, 4'h1, 4'h6, 4'hc, 4'h0, 4'h5};
   localparam logic [7:0] regs [5] = '{8'h16, 8'h17, 8'h18, 8'h19, 8'h20};
   tpts_sequencer DUT (.CLOCK(clock), .RESET(reset), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
      .RDATA(rdata), .TRANSMIT_LINE_CLOCK(tlc), .STEP_CLOCK(step), .MARK_POS(mp_in), .MARK_NEG(mn_in),
      .POS_LINE_OUTPUT(po), .NEG_LINE_OUTPUT(no), .POS_GROUND(pg), .NEG_GROUND(ng));
   tpts_line_model xfmr (.pos_code(po), .neg_code(no), .pos_gnd(pg), .neg_gnd(ng), .swing(swing));
   task automatic check(input logic [15:0] seen, input logic [15:0] want, input string what);
      checked++;
      if (seen !== want) begin
         failures++;
         $display("BAD %0t %s seen %h want %h", $time, what, seen, want);
      end
   endtask
   task automatic stop_test();
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clock);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge clock);
      addr <= a;
      rd <= 1'b1;
      @(posedge clock);
      rd <= 1'b0;
      #1;
      d = rdata;
   endtask
   // one line clock cycle; the step clock stands still outside it
   task automatic pulse(input logic mp, input logic mn, input logic en);
      logic [9:0] want;
      logic [3:0] c;
      logic signed [5:0] ws;
      logic on_pos;
      @(posedge clock);
      tlc <= 1'b0;
      mp_in <= mp;
      mn_in <= mn;
      for (int i = 0; i < 9; i++) begin
         @(posedge clock);
         step <= 1'b1;
         repeat (4) @(posedge clock);
         step <= 1'b0;
         repeat (3) @(posedge clock);
         #1;
         c = (en && (mp || mn) && i < 8) ? cv[i] : 4'h0;
         on_pos = mp ? (i < 4) : (i >= 4);
         want = (!en || !(mp || mn) || i == 8) ? 10'h003 : on_pos ? {c, 6'h01} : {4'h0, c, 2'b10};
         ws = on_pos ? $signed({2'b00, c}) : -$signed({2'b00, c});
         check({6'h0, po, no, pg, ng}, {6'h0, want}, "line outputs");
         check(16'(swing), 16'(ws), "line swing");
      end
      @(posedge clock);
      tlc <= 1'b1;
      repeat (8) @(posedge clock);
   endtask
   task automatic test_regs();
      logic [7:0] d;
      wr_reg(8'h20, 8'hff);
      foreach (regs[i]) begin
         rd_reg(regs[i], d);
         check({8'h0, d}, 16'h0000, "reset read");
      end
      wr_reg(SHAPER_CONFIG_ADDR, 8'h00);
      for (int i = 0; i < ENTRY_COUNT; i++) begin
         wr_reg(WAVEFORM_ENTRY_INDEX_ADDR, 8'(i));
         wr_reg(WAVEFORM_ENTRY_VALUE_ADDR, {4'ha, cv[i]});
      end
      // reverse order and a stray high index bit, so a stuck index shows
      for (int i = ENTRY_COUNT - 1; i >= 0; i--) begin
         wr_reg(WAVEFORM_ENTRY_INDEX_ADDR, 8'(i) | 8'h08);
         rd_reg(WAVEFORM_ENTRY_INDEX_ADDR, d);
         check({8'h0, d}, 16'(i), "index read back");
         rd_reg(WAVEFORM_ENTRY_VALUE_ADDR, d);
         check({8'h0, d}, {12'h0, cv[i]}, "entry read back");
      end
      $display("test regs done");
   endtask
   task automatic test_pulses();
      logic [7:0] d;
      pulse(1'b1, 1'b0, 1'b0);
      wr_reg(SHAPER_CONFIG_ADDR, 8'h01);
      pulse(1'b1, 1'b0, 1'b1);
      pulse(1'b0, 1'b1, 1'b1);
      // status keeps the polarity and activity of the last pulse
      rd_reg(SHAPER_STATUS_ADDR, d);
      check({8'h0, d}, 16'h0060, "status after negative mark");
      pulse(1'b1, 1'b1, 1'b1);
      pulse(1'b0, 1'b0, 1'b1);
      $display("test pulses done");
   endtask
   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end
   initial begin
      repeat (20000) @(posedge clock);
      failures++;
      stop_test();
   end
   initial begin
      {reset, addr, wdata, wr, rd, tlc, step, mp_in, mn_in} = {1'b1, 16'h0, 2'b00, 1'b1, 3'b000};
      failures = 0;
      checked = 0;
      repeat (5) @(posedge clock);
      reset <= 1'b0;
      test_regs();
      test_pulses();
      stop_test();
   end
endmodule
